// ---- logic/pcs_params.svh ----
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

`define PCS_PC_W 15
`define PCS_HI_W 7
`define PCS_SP_W 5
`define PCS_DEPTH 16
`define PCS_IDX_W 13

// Register indices; byte address is four times the index
`define PCS_IDX_LOW 13'h0002
`define PCS_IDX_LATCH 13'h000A
`define PCS_IDX_SHADOW 13'h1FE7
`define PCS_IDX_SP 13'h1FED
`define PCS_IDX_TOS_LOW 13'h1FEE
`define PCS_IDX_TOS_HIGH 13'h1FEF

`define PCS_PC_RST 15'h0000
`define PCS_LATCH_RST 7'h00
`define PCS_SHADOW_RST 7'h00
`define PCS_SP_RST 5'h1F

// Call operand, latch page and branch operand field positions
`define PCS_CALL_LO 10
`define PCS_LATCH_PG 3
`define PCS_BR_IMM_MSB 8

`endif

// ---- logic/pcs_pkg.sv ----
package pcs_pkg;

  typedef enum logic [2:0] {
    PCS_OP_STEP = 3'h0,
    PCS_OP_WRITE_LOW = 3'h1,
    PCS_OP_ADD_LOW = 3'h2,
    PCS_OP_CALL_ABS = 3'h3,
    PCS_OP_CALL_W = 3'h4,
    PCS_OP_BR_WORK = 3'h5,
    PCS_OP_BR_IMM = 3'h6,
    PCS_OP_RETURN = 3'h7
  } pcs_kind_type;

  typedef struct packed {
    logic valid;
    pcs_kind_type kind;
    logic [10:0] operand;
    logic [7:0] working;
    logic [7:0] data;
  } pcs_op_type;

  typedef struct packed {
    logic push;
    logic pop;
    logic sp_wr;
    logic tos_low_wr;
    logic tos_high_wr;
    logic [14:0] data;
  } pcs_stack_req_type;

endpackage : pcs_pkg

// ---- logic/pcs_stack.sv ----
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_stack
  import pcs_pkg::*;
(
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, active low
  input wire pcs_stack_req_type req, // Push, pop and software writes
  output logic [4:0] sp, // Current stack pointer
  output logic [14:0] tos // Entry under the pointer
);

  logic [14:0] mem [`PCS_DEPTH];
  logic [4:0] sp_q;
  logic [4:0] sp_inc;

  assign sp_inc = sp_q + 5'h01;
  assign sp = sp_q;
  assign tos = mem[sp_q[3:0]];

  // Pointer wraps, so the stack behaves as a circular buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= `PCS_SP_RST;
    end else if (req.push) begin
      sp_q <= sp_inc;
    end else if (req.pop) begin
      sp_q <= sp_q - 5'h01;
    end else if (req.sp_wr) begin
      sp_q <= req.data[4:0];
    end
  end

  // Storage needs no reset; contents are unknown until pushed
  always_ff @(posedge hclk) begin
    if (req.push) begin
      mem[sp_inc[3:0]] <= req.data;
    end else if (req.tos_low_wr) begin
      mem[sp_q[3:0]][7:0] <= req.data[7:0];
    end else if (req.tos_high_wr) begin
      mem[sp_q[3:0]][14:8] <= req.data[14:8];
    end
  end

endmodule : pcs_stack

// ---- logic/pcs_next.sv ----
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_next
  import pcs_pkg::*;
(
  input wire logic [14:0] pc, // Current counter
  input wire logic [6:0] latch, // High-address latch
  input wire logic [14:0] tos, // Top of return stack
  input wire pcs_op_type op, // Decoded operation
  output logic [14:0] next_pc, // Counter after the operation
  output logic [14:0] ret_pc // Return address to push
);

  logic [14:0] inc;
  logic [14:0] imm_ofs;
  logic [7:0] low_sum;

  assign inc = pc + 15'h0001;
  assign ret_pc = inc;
  assign imm_ofs = {{6{op.operand[`PCS_BR_IMM_MSB]}}, op.operand[`PCS_BR_IMM_MSB:0]};
  // Sum is cut to eight bits so no carry reaches the upper part
  assign low_sum = inc[7:0] + op.working;

  always_comb begin
    next_pc = inc;
    if (op.valid) begin
      unique case (op.kind)
        PCS_OP_STEP: next_pc = inc;
        PCS_OP_WRITE_LOW: next_pc = {latch, op.data};
        PCS_OP_ADD_LOW: next_pc = {latch, low_sum};
        PCS_OP_CALL_ABS: next_pc = {latch[6:`PCS_LATCH_PG], op.operand[`PCS_CALL_LO:0]};
        PCS_OP_CALL_W: next_pc = {latch, op.working};
        PCS_OP_BR_WORK: next_pc = inc + {7'h00, op.working};
        PCS_OP_BR_IMM: next_pc = inc + imm_ofs;
        PCS_OP_RETURN: next_pc = tos;
      endcase
    end else begin
      next_pc = pc;
    end
  end

endmodule : pcs_next

// ---- logic/pcs_core.sv ----
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_core
  import pcs_pkg::*;
(
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data, registered
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire pcs_op_type op, // Operation from the decoder
  output logic [14:0] fetch_addr, // Counter, fetch address
  output logic [6:0] latch_out, // High-address latch
  output logic [4:0] stack_ptr // Stack pointer
);

  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [6:0] latch_q;
  logic [6:0] shadow_q;
  logic ph_q;
  logic wr_q;
  logic rd_done_q;
  logic [12:0] idx_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_val;
  logic accept;
  logic bus_wr;
  logic rd_wait;
  logic [14:0] op_pc;
  logic [14:0] ret_pc;
  logic [14:0] tos;
  logic [4:0] sp;
  logic is_call;
  logic is_return;
  logic wr_low;
  logic wr_latch;
  logic wr_shadow;
  logic wr_sp;
  logic wr_tos_low;
  logic wr_tos_high;
  pcs_stack_req_type sreq;

  // Bus slave: writes take no wait state, reads one
  assign accept = hsel && htrans[1] && hready;
  assign rd_wait = ph_q && !wr_q && !rd_done_q;
  assign bus_wr = ph_q && wr_q;
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Capture only while ready, so a request held through a wait state is not taken twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
    end else if (hready) begin
      ph_q <= accept;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
    end else if (hready) begin
      wr_q <= hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= 13'h0000;
    end else if (hready) begin
      idx_q <= haddr[14:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_wait;
    end
  end

  // Read data is loaded in the wait cycle and then stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_wait) begin
      rdata_q <= rd_val;
    end
  end

  // One strobe per register keeps the write decode in a single place
  assign wr_low = bus_wr && idx_q == `PCS_IDX_LOW;
  assign wr_latch = bus_wr && idx_q == `PCS_IDX_LATCH;
  assign wr_shadow = bus_wr && idx_q == `PCS_IDX_SHADOW;
  assign wr_sp = bus_wr && idx_q == `PCS_IDX_SP;
  assign wr_tos_low = bus_wr && idx_q == `PCS_IDX_TOS_LOW;
  assign wr_tos_high = bus_wr && idx_q == `PCS_IDX_TOS_HIGH;

  // Unmapped reads return zero; upper counter bits have no index
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (idx_q)
      `PCS_IDX_LOW: rd_val[7:0] = pc_q[7:0];
      `PCS_IDX_LATCH: rd_val[6:0] = latch_q;
      `PCS_IDX_SHADOW: rd_val[6:0] = shadow_q;
      `PCS_IDX_SP: rd_val[4:0] = sp;
      `PCS_IDX_TOS_LOW: rd_val[7:0] = tos[7:0];
      `PCS_IDX_TOS_HIGH: rd_val[6:0] = tos[14:8];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q <= `PCS_LATCH_RST;
    end else if (wr_latch) begin
      latch_q <= hwdata[6:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_q <= `PCS_SHADOW_RST;
    end else if (wr_shadow) begin
      shadow_q <= hwdata[6:0];
    end
  end

  pcs_next u_next (
    .pc(pc_q),
    .latch(latch_q),
    .tos(tos),
    .op(op),
    .next_pc(op_pc),
    .ret_pc(ret_pc)
  );

  // A decoder operation wins over a bus write in the same cycle
  always_comb begin
    pc_d = op_pc;
    if (!op.valid && wr_low) begin
      pc_d = {latch_q, hwdata[7:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= `PCS_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  assign is_call = op.valid && (op.kind == PCS_OP_CALL_ABS || op.kind == PCS_OP_CALL_W);
  assign is_return = op.valid && op.kind == PCS_OP_RETURN;

  // Software stack writes give way to a call or return in the same cycle
  always_comb begin
    sreq.push = is_call;
    sreq.pop = is_return;
    sreq.sp_wr = wr_sp;
    sreq.tos_low_wr = wr_tos_low && !is_return;
    sreq.tos_high_wr = wr_tos_high && !is_return;
    sreq.data = is_call ? ret_pc : {hwdata[6:0], hwdata[7:0]};
  end

  pcs_stack u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(sreq),
    .sp(sp),
    .tos(tos)
  );

  assign fetch_addr = pc_q;
  assign latch_out = latch_q;
  assign stack_ptr = sp;

endmodule : pcs_core

// ---- testbench/pcs_tb_pkg.sv ----
package pcs_tb_pkg;
  import pcs_pkg::*;

  function automatic logic [14:0] nxt(input logic [14:0] p, input pcs_op_type o, input logic [6:0] l);
    case (o.kind)
      PCS_OP_WRITE_LOW: return {l, o.data};
      PCS_OP_ADD_LOW: return {l, 8'(p[7:0] + 8'h01 + o.working)};
      PCS_OP_CALL_ABS: return {l[6:3], o.operand};
      PCS_OP_CALL_W: return {l, o.working};
      PCS_OP_BR_WORK: return 15'(p + 15'h0001 + {7'h00, o.working});
      PCS_OP_BR_IMM: return 15'(p + 15'h0001 + {{6{o.operand[8]}}, o.operand[8:0]});
      default: return 15'(p + 15'h0001);
    endcase
  endfunction : nxt
endpackage : pcs_tb_pkg

// ---- testbench/pcs_dec_model.sv ----
`timescale 1ns/1ps
module pcs_dec_model
  import pcs_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic slow, // Stall between issues
  input wire pcs_op_type req, // Next instruction
  output pcs_op_type op // Issued to the core
);
  logic gap_q;
  // A slow fetch leaves an empty slot after each issue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op <= '0;
      gap_q <= 1'b0;
    end else begin
      op <= (slow && gap_q) ? '0 : req;
      gap_q <= slow && !gap_q;
    end
  end
endmodule : pcs_dec_model

// ---- testbench/pcs_core_props.sv ----
`timescale 1ns/1ps
module pcs_core_chk
  import pcs_pkg::*, pcs_tb_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire pcs_op_type op, // Operation
  input wire logic [14:0] fetch_addr, // Counter
  input wire logic [6:0] latch_out, // Latch
  input wire logic [4:0] stack_ptr // Pointer
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic [14:0] exp_q;
  always_ff @(posedge hclk) exp_q <= nxt(fetch_addr, op, latch_out);
  sequence rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property kind_p(pcs_kind_type k);
    op.valid && op.kind == k |=> fetch_addr == exp_q;
  endproperty
  counter_clear_a: assert property ($rose(hresetn) |-> fetch_addr == 15'h0000) else $error("no clear");
  low_write_a: assert property (kind_p(PCS_OP_WRITE_LOW)) else $error("low write");
  add_low_a: assert property (kind_p(PCS_OP_ADD_LOW)) else $error("add low");
  call_abs_a: assert property (kind_p(PCS_OP_CALL_ABS)) else $error("call abs");
  call_work_a: assert property (kind_p(PCS_OP_CALL_W)) else $error("call work");
  branch_work_a: assert property (kind_p(PCS_OP_BR_WORK)) else $error("branch by working");
  branch_imm_a: assert property (kind_p(PCS_OP_BR_IMM)) else $error("branch immediate");
  call_push_a: assert property (op.valid && (op.kind == PCS_OP_CALL_W || op.kind == PCS_OP_CALL_ABS)
    |=> stack_ptr == $past(stack_ptr) + 5'h01) else $error("push");
  read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> rd_ans) else $error("read");
endmodule : pcs_core_chk

bind pcs_core pcs_core_chk u_chk (.*);

// ---- testbench/program_counter_load_logic_bench.sv ----
`timescale 1ns/1ps
`include "pcs_params.svh"
module program_counter_load_logic_bench;
  import pcs_pkg::*, pcs_tb_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic hreadyout, hresp;
  pcs_op_type req = '0;
  pcs_op_type op;
  logic [14:0] fetch_addr, ep;
  // Sixteen entries, so a wrapped pointer overwrites just as the core does
  logic [14:0] stk [16];
  logic [6:0] latch_out;
  logic [6:0] lat = 7'h00;
  logic [4:0] stack_ptr, sp;
  logic [15:0] rnd = 16'h0014;
  int err_count = 0;
  int comparisons = 0;
  logic [12:0] ri [5] = '{`PCS_IDX_LOW, `PCS_IDX_LATCH, `PCS_IDX_SHADOW, `PCS_IDX_SP, 13'h0001};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h1F, 32'h0};
  // Low byte wrap, backward block crossing, then a call and its return
  pcs_op_type cs [5] = '{'{1'b1, PCS_OP_WRITE_LOW, 11'h0, 8'h0, 8'hFF},
    '{1'b1, PCS_OP_ADD_LOW, 11'h0, 8'h05, 8'h0}, '{1'b1, PCS_OP_BR_IMM, 11'h100, 8'h0, 8'h0},
    '{1'b1, PCS_OP_CALL_W, 11'h0, 8'h34, 8'h0}, '{1'b1, PCS_OP_RETURN, 11'h0, 8'h0, 8'h0}};

  always #50 hclk = ~hclk;
  pcs_core DUT (.*, .hsize(3'h2), .hready(hreadyout));
  pcs_dec_model u_dec (.*);

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [12:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {17'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50) chk(32'h0, 32'h1, "bus stuck");
  endtask : bus

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Reference counter and return stack follow the ops the core really saw
  always @(posedge hclk) begin
    if (!hresetn) begin
      ep <= 15'h0000;
      sp <= 5'h1F;
    end else if (op.valid) begin
      if (op.kind == PCS_OP_RETURN) begin
        ep <= stk[sp[3:0]];
        sp <= sp - 5'h01;
      end else ep <= nxt(ep, op, lat);
      if (op.kind == PCS_OP_CALL_W || op.kind == PCS_OP_CALL_ABS) begin
        sp <= sp + 5'h01;
        stk[4'(sp + 5'h01)] <= ep + 15'h0001;
      end
    end
  end

  always @(negedge hclk) if (hresetn) begin
    chk({17'h0, fetch_addr}, {17'h0, ep}, "counter");
    chk({27'h0, stack_ptr}, {27'h0, sp}, "pointer");
    chk({25'h0, latch_out}, {25'h0, lat}, "latch");
    chk({31'h0, hresp}, 32'h0, "response");
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ri[i]) begin
      bus(1'b0, ri[i], 32'h0, d);
      chk(d, rv[i], "reset value");
    end
    bus(1'b1, `PCS_IDX_LATCH, 32'h5A, d);
    lat = 7'h5A;
    bus(1'b1, `PCS_IDX_LOW, 32'hC3, d);
    ep = {lat, 8'hC3};
    bus(1'b0, `PCS_IDX_LOW, 32'h0, d);
    chk(d, 32'hC3, "low byte");
    repeat (300) begin
      @(posedge hclk);
      rnd = lfsr(rnd);
      slow <= rnd[12];
      req <= '{1'b1, pcs_kind_type'(rnd[2:0] % 3'h7), rnd[13:3], rnd[15:8], rnd[7:0]};
    end
    foreach (cs[i]) begin
      @(posedge hclk);
      slow <= 1'b0;
      req <= cs[i];
    end
    @(posedge hclk);
    req <= '0;
    // Stack registers from software, after the return has settled the pointer
    bus(1'b0, `PCS_IDX_SP, 32'h0, d);
    chk(d, {27'h0, sp}, "pointer read");
    bus(1'b0, `PCS_IDX_TOS_LOW, 32'h0, d);
    chk(d, {24'h0, stk[sp[3:0]][7:0]}, "return low");
    bus(1'b0, `PCS_IDX_TOS_HIGH, 32'h0, d);
    chk(d, {25'h0, stk[sp[3:0]][14:8]}, "return high");
    bus(1'b1, `PCS_IDX_TOS_LOW, 32'hFFFF_FFA5, d);
    bus(1'b1, `PCS_IDX_TOS_HIGH, 32'h0000_0036, d);
    bus(1'b0, `PCS_IDX_TOS_LOW, 32'h0, d);
    chk(d, 32'h0000_00A5, "stack low write");
    bus(1'b0, `PCS_IDX_TOS_HIGH, 32'h0, d);
    chk(d, 32'h0000_0036, "stack high write");
    bus(1'b1, `PCS_IDX_SHADOW, 32'hFFFF_FFBC, d);
    bus(1'b0, `PCS_IDX_SHADOW, 32'h0, d);
    chk(d, 32'h0000_003C, "shadow");
    bus(1'b1, `PCS_IDX_SP, {27'h0, 5'(sp + 5'h03)}, d);
    sp = sp + 5'h03;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    lat = 7'h00;
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({17'h0, fetch_addr}, 32'h0, "second reset");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge hclk);
    chk(32'h0, 32'h1, "timeout");
    wrap_up();
  end
endmodule : program_counter_load_logic_bench
